// ### hdl/sadc_cfg.svh
// Timing and layout constants for the conversion sequencer.
// Assumes a 20 MHz system clock; included by the package and the top.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SADC_CLK_NS 50
// Base conversion time in ns (3.8 us)
`define SADC_CONV_BASE_NS 3800
`define SADC_CONV_BASE_CYC ((`SADC_CONV_BASE_NS) / (`SADC_CLK_NS))
// Oversampled unit in ns; unit << ratio sits inside the busy band of every ratio code from 1 to 6
`define SADC_CONV_OS_NS 4300
`define SADC_CONV_OS_CYC ((`SADC_CONV_OS_NS) / (`SADC_CLK_NS))
// Start-to-busy delay in ns, longest
`define SADC_START_BUSY_NS 15
// Field widths and channel count
`define SADC_RESULT_W 16
`define SADC_OS_W 3
`define SADC_CHAN_N 8
`define SADC_CNT_W 16
// Highest oversampling code (ratio 64)
`define SADC_OS_MAX 3'h6

`endif

// ### hdl/sadc_pkg.sv
// Types shared by the conversion sequencer.
// Assumes sadc_cfg.svh is on the include path.
`default_nettype none
`include "sadc_cfg.svh"
package sadc_pkg;
   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      SADC_IDLE,
      SADC_CONV,
      SADC_LOWP
   } sadc_state_type;

   // Read bus drive group
   typedef struct packed {
      logic [`SADC_RESULT_W-1:0] data;
      logic data_oe;
      logic first;
      logic first_oe;
   } sadc_rd_type;
endpackage : sadc_pkg
`default_nettype wire

// ### hdl/sadc_top.sv
// Conversion sequencing and parallel read-out for an eight-channel
// simultaneous-sampling converter. Host pins arrive asynchronously and
// are synchronised; results come from a user-side sample port.
`timescale 1ns/1ns
`default_nettype none
`include "sadc_cfg.svh"

module sadc_top (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic start_group_a_i,
   input wire logic start_group_b_i,
   input wire logic low_power_n_i,
   input wire logic [`SADC_OS_W-1:0] oversample_select_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic [`SADC_CHAN_N*`SADC_RESULT_W-1:0] sample_i,
   output logic busy_o,
   output logic [`SADC_OS_W-1:0] ratio_o,
   output logic [`SADC_RESULT_W-1:0] result_bus_o,
   output logic result_bus_oe_o,
   output logic first_channel_flag_o,
   output logic first_channel_flag_oe_o
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0] meta_r; // First stage, read only by sync_r
   logic [4:0] sync_r; // Second stage
   logic [4:0] sync_nxt;
   logic [4:0] prev_r; // Delayed copy for edge detect
   logic [`SADC_OS_W-1:0] os_meta_r;
   logic [`SADC_OS_W-1:0] os_sync_r;

   // Two-flop capture of every host pin
   always_comb begin
      sync_nxt = {start_group_a_i, start_group_b_i, low_power_n_i,
                  cs_n_i, rd_n_i};
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // Idle pin levels: starts low, awake, select and strobe high
         meta_r <= 5'h07;
         sync_r <= 5'h07;
         prev_r <= 5'h07;
         os_meta_r <= 3'h0;
         os_sync_r <= 3'h0;
      end else begin
         meta_r <= sync_nxt;
         sync_r <= meta_r;
         prev_r <= sync_r;
         os_meta_r <= oversample_select_i;
         os_sync_r <= os_meta_r;
      end
   end

   logic sa;
   logic sb;
   logic awake;
   logic sel_n;
   logic rise_a;
   logic rise_b;
   assign sa = sync_r[4];
   assign sb = sync_r[3];
   assign awake = sync_r[2];
   assign sel_n = sync_r[1] | sync_r[0];
   assign rise_a = sa & ~prev_r[4];
   assign rise_b = sb & ~prev_r[3];

   // ****************************************
   // Conversion sequencer
   // ****************************************
   sadc_pkg::sadc_state_type state_r;
   sadc_pkg::sadc_state_type state_nxt;
   logic seen_a_r; // Group A start seen
   logic seen_a_nxt;
   logic seen_b_r; // Group B start seen
   logic seen_b_nxt;
   logic [`SADC_CNT_W-1:0] cnt_r; // Conversion cycles left
   logic [`SADC_CNT_W-1:0] cnt_nxt;
   logic [`SADC_OS_W-1:0] ratio_r; // Active oversampling code
   logic [`SADC_OS_W-1:0] ratio_nxt;
   logic [`SADC_CHAN_N*`SADC_RESULT_W-1:0] hold_r; // Captured results
   logic [`SADC_CHAN_N*`SADC_RESULT_W-1:0] hold_nxt;

   // Next state, counts and captures
   always_comb begin
      state_nxt = state_r;
      seen_a_nxt = seen_a_r | rise_a;
      seen_b_nxt = seen_b_r | rise_b;
      cnt_nxt = cnt_r;
      ratio_nxt = ratio_r;
      hold_nxt = hold_r;
      unique case (state_r)
         sadc_pkg::SADC_IDLE: begin
            if (!awake) begin
               // Standby drops pending starts
               state_nxt = sadc_pkg::SADC_LOWP;
               seen_a_nxt = 1'b0;
               seen_b_nxt = 1'b0;
            end else if (seen_a_nxt && seen_b_nxt) begin
               // Later start edge launches conversion
               state_nxt = sadc_pkg::SADC_CONV;
               seen_a_nxt = 1'b0;
               seen_b_nxt = 1'b0;
               // Oversampled unit shifted by ratio
               // Plain rate uses the base time, else unit << ratio
               cnt_nxt = (ratio_r == 3'h0)
                  ? `SADC_CNT_W'(`SADC_CONV_BASE_CYC)
                  : `SADC_CNT_W'(`SADC_CONV_OS_CYC << ratio_r);
            end
         end
         sadc_pkg::SADC_CONV: begin
            seen_a_nxt = 1'b0;
            seen_b_nxt = 1'b0;
            if (cnt_r <= `SADC_CNT_W'(1)) begin
               // Busy falls: capture results, take new ratio
               state_nxt = sadc_pkg::SADC_IDLE;
               cnt_nxt = '0;
               hold_nxt = sample_i;
               ratio_nxt = (os_sync_r > `SADC_OS_MAX) ? `SADC_OS_MAX
                                                      : os_sync_r;
            end else begin
               cnt_nxt = cnt_r - `SADC_CNT_W'(1);
            end
         end
         sadc_pkg::SADC_LOWP: begin
            // Wake-up wait is the host's duty
            seen_a_nxt = 1'b0;
            seen_b_nxt = 1'b0;
            if (awake) begin
               state_nxt = sadc_pkg::SADC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= sadc_pkg::SADC_IDLE;
         seen_a_r <= 1'b0;
         seen_b_r <= 1'b0;
         cnt_r <= '0;
         ratio_r <= 3'h0;
         hold_r <= '0;
      end else begin
         state_r <= state_nxt;
         seen_a_r <= seen_a_nxt;
         seen_b_r <= seen_b_nxt;
         cnt_r <= cnt_nxt;
         ratio_r <= ratio_nxt;
         hold_r <= hold_nxt;
      end
   end

   // ****************************************
   // Parallel read-out
   // ****************************************
   sadc_pkg::sadc_rd_type rd_r; // Registered bus drive
   sadc_pkg::sadc_rd_type rd_nxt;
   logic [2:0] chan_r; // Next channel to present
   logic [2:0] chan_nxt;
   logic [`SADC_RESULT_W-1:0] word [`SADC_CHAN_N];

   // Slice captured results per channel
   genvar gi;
   generate
      for (gi = 0; gi < `SADC_CHAN_N; gi++) begin : g_word
         assign word[gi] = hold_r[gi*`SADC_RESULT_W +: `SADC_RESULT_W];
      end
   endgenerate

   // Bus drive follows the select/strobe low phase
   always_comb begin
      rd_nxt = rd_r;
      chan_nxt = chan_r;
      if (!sel_n && (prev_r[1] | prev_r[0])) begin
         // Falling edge: drive bus and flag
         rd_nxt.data = word[chan_r];
         rd_nxt.data_oe = 1'b1;
         rd_nxt.first = (chan_r == 3'h0);
         rd_nxt.first_oe = 1'b1;
         chan_nxt = chan_r + 3'h1;
      end else if (sel_n) begin
         // Select or strobe high: release to high impedance
         rd_nxt.data_oe = 1'b0;
         rd_nxt.first_oe = 1'b0;
      end
      if (state_r == sadc_pkg::SADC_CONV && cnt_r <= `SADC_CNT_W'(1)) begin
         // New results restart at channel one
         chan_nxt = 3'h0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_r <= '0;
         chan_r <= 3'h0;
      end else begin
         rd_r <= rd_nxt;
         chan_r <= chan_nxt;
      end
   end

   assign busy_o = (state_r == sadc_pkg::SADC_CONV);
   assign ratio_o = ratio_r;
   assign result_bus_o = rd_r.data;
   assign result_bus_oe_o = rd_r.data_oe;
   assign first_channel_flag_o = rd_r.first;
   assign first_channel_flag_oe_o = rd_r.first_oe;

   // ****************************************
   // Checks
   // ****************************************
   AST_BUSY_RISE: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_r == sadc_pkg::SADC_IDLE && awake && seen_a_nxt && seen_b_nxt)
      |=> busy_o)
      else $error("busy did not rise after both starts");
   AST_BUSY_LEN: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ($rose(busy_o) && ratio_r == 3'h0) |-> busy_o [*8])
      else $error("busy too short");
   AST_BUSY_END: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ($rose(busy_o) && ratio_r == 3'h0) |-> ##[70:80] !busy_o)
      else $error("busy length wrong at ratio one");
   AST_RATIO_HOLD: assert property (@(posedge clock_i) disable iff (!resetn_i)
      busy_o |=> $stable(ratio_r) || $fell(busy_o))
      else $error("ratio changed during conversion");
   AST_BUS_OFF: assert property (@(posedge clock_i) disable iff (!resetn_i)
      sel_n |=> !result_bus_oe_o && !first_channel_flag_oe_o)
      else $error("bus driven after select rose");
   AST_BUS_ON: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $fell(sel_n) |=> result_bus_oe_o)
      else $error("bus not driven on select fall");
   AST_FIRST_CH: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ($fell(sel_n) && chan_r == 3'h0 && !busy_o)
      |=> first_channel_flag_o && first_channel_flag_oe_o)
      else $error("first-channel flag wrong");
   AST_LOWP: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_r == sadc_pkg::SADC_LOWP) |=> !busy_o)
      else $error("conversion started in low power");

endmodule : sadc_top
`default_nettype wire

// ### bench/sadc_host.sv
// Host controller model: starts, power control and read strobes.
// Assumes the 20 MHz clock; pins move on its falling edge.
`timescale 1ns/1ns
`default_nettype none
module sadc_host (
   input wire logic clock_i,
   output logic start_a_o,
   output logic start_b_o,
   output logic low_power_n_o,
   output logic [2:0] select_o,
   output logic sel_n_o
);
   // ****
   // Idle levels and pin tasks
   // ****
   initial begin
      {start_a_o, start_b_o, low_power_n_o, select_o, sel_n_o} = 7'h11;
   end
   // Ratio set along with start B, far from busy fall
   task automatic pulse(input logic [2:0] r);
      @(negedge clock_i) select_o <= r;
      start_b_o <= 1'b1;
      @(negedge clock_i) start_a_o <= 1'b1;
      repeat (3) @(negedge clock_i);
      start_a_o <= 1'b0;
      start_b_o <= 1'b0;
   endtask : pulse
   // Select and strobe tied, low phase 250 ns
   task automatic read_phase();
      @(negedge clock_i) sel_n_o <= 1'b0;
      repeat (5) @(negedge clock_i);
   endtask : read_phase
   // High phase 250 ns
   task automatic release_phase();
      sel_n_o <= 1'b1;
      repeat (5) @(negedge clock_i);
   endtask : release_phase
   // Standby in, then out with a full wake wait
   task automatic power(input logic on);
      low_power_n_o <= on;
      repeat (on ? 2000 : 1) @(negedge clock_i);
   endtask : power
endmodule : sadc_host
`default_nettype wire

// ### bench/tb_simultaneous_adc_conversion_sequencing.sv
// Self-checking bench for the conversion sequencer.
// Assumes sadc_top and sadc_host are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "sadc_cfg.svh"
module tb_simultaneous_adc_conversion_sequencing;
   logic clock_i, resetn_i, busy_o, oe, first, first_oe;
   logic sa, sb, lpn, sel_n;
   logic [2:0] ratio_o, os;
   logic [15:0] bus;
   logic [127:0] sample;
   logic [15:0] q[$];
   integer fail_count = 0, check_count = 0, seed = 32'h3be6, mr = 0, n;
   // Busy-time bands in ns per ratio code
   int lo_ns[7] = '{3700, 8400, 17000, 34000, 68000, 136000, 272000};
   int hi_ns[7] = '{3900, 8800, 18000, 36000, 72000, 144000, 288000};
   // ****
   // Design and host
   // ****
   sadc_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
      .start_group_a_i(sa), .start_group_b_i(sb), .low_power_n_i(lpn),
      .oversample_select_i(os), .cs_n_i(sel_n), .rd_n_i(sel_n),
      .sample_i(sample), .busy_o(busy_o), .ratio_o(ratio_o),
      .result_bus_o(bus), .result_bus_oe_o(oe),
      .first_channel_flag_o(first), .first_channel_flag_oe_o(first_oe));
   sadc_host host_u (.clock_i(clock_i), .start_a_o(sa), .start_b_o(sb),
      .low_power_n_o(lpn), .select_o(os), .sel_n_o(sel_n));
   // ****
   // Compare and verdict
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   // One conversion, a refused restart inside it, then nine reads
   // Starts spaced far past 5 us by busy time plus reads
   task automatic conv(input logic [2:0] r);
      logic [127:0] s;
      int busy_ns;
      s = {$random(seed), $random(seed), $random(seed), $random(seed)};
      sample <= s;
      q = {};
      for (n = 0; n < 8; n++) q.push_back(s[n*16 +: 16]);
      fork host_u.pulse(r); join_none
      n = 0;
      while (busy_o !== 1'b1 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      check(n <= 7, 1);
      n = 0;
      while (busy_o === 1'b1 && n < 6000) begin
         n++;
         @(negedge clock_i);
         if (n == 30) fork host_u.pulse(r); join_none
      end
      check(n, mr ? `SADC_CONV_OS_CYC << mr : `SADC_CONV_BASE_CYC);
      busy_ns = n * `SADC_CLK_NS;
      check(busy_ns >= lo_ns[mr] && busy_ns <= hi_ns[mr], 1);
      mr = r > 6 ? 6 : r;
      repeat (2) @(negedge clock_i);
      check(ratio_o, mr);
      for (n = 0; n < 9; n++) begin
         host_u.read_phase();
         check({oe, first_oe, first, bus}, {2'h3, n % 8 == 0, q[n % 8]});
         host_u.release_phase();
         check({oe, first_oe}, 0);
      end
   endtask : conv
   // ****
   // Clock, watchdog, sequence
   // ****
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   initial begin
      #2000000;
      fail_count++;
      close_out();
   end
   initial begin
      resetn_i = 1'b0;
      sample = '0;
      repeat (2) @(negedge clock_i);
      resetn_i <= 1'b1;
      repeat (500) @(negedge clock_i);
      check({busy_o, ratio_o, oe, first_oe}, 0);
      for (integer r = 0; r < 8; r++) conv(r[2:0]);
      host_u.power(1'b0);
      fork host_u.pulse(3'h0); join_none
      repeat (20) @(negedge clock_i);
      check(busy_o, 0);
      host_u.power(1'b1);
      conv(3'h0);
      close_out();
   end
endmodule : tb_simultaneous_adc_conversion_sequencing
`default_nettype wire
